// file: verilog/cgi_pkg.sv
// package: register map, field positions, timing counts and carrier types for the codec gpio port
package cgi_pkg;
    // ==========================================================
    // register byte offsets on the apb
    localparam logic [7:0] OFF_AUDIO_FSEL = 8'h00;
    localparam logic [7:0] OFF_CTRL_FSEL = 8'h04;
    localparam logic [7:0] OFF_AUDIO_DIR = 8'h08;
    localparam logic [7:0] OFF_CTRL_DIR = 8'h0c;
    localparam logic [7:0] OFF_AUDIO_VAL = 8'h10;
    localparam logic [7:0] OFF_CTRL_VAL = 8'h14;
    localparam logic [7:0] OFF_WORD_UPPER = 8'h18;
    localparam logic [7:0] OFF_WORD_LOWER = 8'h1c;
    localparam logic [7:0] OFF_SEQ_CTRL = 8'h20;
    localparam logic [7:0] OFF_SEQ_STAT = 8'h24;
    localparam logic [7:0] OFF_AUDIO_PINS = 8'h28;
    localparam logic [7:0] OFF_CTRL_PINS = 8'h2c;
    // ==========================================================
    // pin positions and field layout
    localparam int PORT_W = 24;
    localparam int PINS = 6;
    localparam int BIT_RESET = 0;
    localparam int BIT_SELECT = 0;
    localparam int BIT_SCLK = 1;
    localparam int BIT_SDATA = 2;
    localparam int SEQ_INIT = 0;
    localparam int SEQ_SEND = 1;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int WORD_W = 16;
    localparam logic [23:0] AUDIO_FSEL_RUN = 24'h00003e;
    localparam logic [23:0] FSEL_RST = 24'h000000;
    localparam logic [23:0] AUDIO_DIR_RST = 24'h000001;
    localparam logic [23:0] CTRL_DIR_RST = 24'h000007;
    localparam logic [23:0] AUDIO_VAL_RST = 24'h000001;
    localparam logic [23:0] CTRL_VAL_RST = 24'h000001;
    // ==========================================================
    // timing
    localparam int CLK_HZ = 10_000_000;
    localparam int RESET_WAIT_MS = 50;
    localparam int RESET_WAIT_CYC = (CLK_HZ / 1000) * RESET_WAIT_MS;
    localparam int HALF_BIT_NS = 2000;
    localparam int HALF_BIT_CYC = (HALF_BIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CNT_W = 20;
    // ==========================================================
    // carriers
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_RESET = 6'b000010,
        ST_LOAD = 6'b000100,
        ST_CLKHI = 6'b001000,
        ST_CLKLO = 6'b010000,
        ST_END = 6'b100000
    } cgi_state_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } cgi_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } cgi_apb_rsp_type;

    typedef struct packed {
        logic [PINS-1:0] dout;
        logic [PINS-1:0] oe;
    } cgi_pins_type;
endpackage

// file: verilog/cgi_pin_sync.sv
// three-stage pin synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module cgi_pin_sync
    import cgi_pkg::*;
#(
    parameter int W = 6
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // pins
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] pinOut
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] val;
    } cgi_sync_type;

    cgi_sync_type state_r;
    cgi_sync_type state_nxt;

    always_comb begin
        state_nxt = state_r;
        state_nxt.s1 = pinIn;
        state_nxt.s2 = state_r.s1;
        state_nxt.s3 = state_r.s2;
        // a change counts only once the second and third stages agree
        for (int i = 0; i < W; i++) begin
            if (state_r.s2[i] == state_r.s3[i]) begin
                state_nxt.val[i] = state_r.s3[i];
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign pinOut = state_r.val;
endmodule

// file: verilog/cgi_codec_gpio_init_port.sv
// codec gpio port: apb registers, pin muxing and codec reset/control sequencer
// ==========================================================
// Functional notes
// [RQ1] audio port function bit 0 zero for reset pin; other five pins one
// [RQ2] control port function bits 0..2 zero so select, clock, data are gpio
// [RQ3] audio serial function stays off (all zero) until codec init completes
// [RQ4] direction bit one makes pin output, zero makes it input
// [RQ5] audio direction bit 0 set so codec reset is driven
// [RQ6] control direction bits 0..2 set: select, clock, data outputs
// [RQ7] order: reset codec, wait, then send control information
// [RQ8] codec reset driven low by clearing audio pin value bit 0
// [RQ9] control select driven low together with codec reset
// [RQ10] hold codec reset at least 50 ms
// [RQ11] release codec reset high before any control transfer
// [RQ12] codec drops first transfer; a dummy set is sent before real
// [RQ13] control words resent only when software asks, no refresh
// [RQ14] transfer is upper word then lower word, separate registers
// [RQ15] codec accepts control only while select is low
// [RQ16] codec takes data on rising control clock edge
// [RQ17] codec starts a frame on rising frame pulse
// [RQ18] codec samples on rising bit clock, launches on falling
// [RQ19] sixteen bits msb first: clock high, set data, clock low, shift
// [RQ20] select low across both words, returned high after lower word
// [RQ21] pin driven only when gpio and direction is output
// [RQ22] reset wait and clock half period counts derive from clock rate
`timescale 1ns/1ps
module cgi_codec_gpio_init_port
    import cgi_pkg::*;
#(
    parameter int RESET_WAIT = RESET_WAIT_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // apb slave
    input wire cgi_apb_req_type apbReq,
    output cgi_apb_rsp_type apbRsp,
    // audio port pins
    input wire logic [PINS-1:0] audioPinIn,
    output cgi_pins_type audioPins,
    // control port pins
    input wire logic [PINS-1:0] ctrlPinIn,
    output cgi_pins_type ctrlPins
);
    typedef struct packed {
        logic [PORT_W-1:0] audioFsel;
        logic [PORT_W-1:0] ctrlFsel;
        logic [PORT_W-1:0] audioDir;
        logic [PORT_W-1:0] ctrlDir;
        logic [PORT_W-1:0] audioVal;
        logic [PORT_W-1:0] ctrlVal;
        logic [WORD_W-1:0] wordUpper;
        logic [WORD_W-1:0] wordLower;
        cgi_state_type fsm;
        logic [CNT_W-1:0] cnt;
        logic [WORD_W-1:0] shift;
        logic [4:0] bitCnt;
        logic second;
        logic dummy;
        logic done;
        logic [31:0] prdata;
    } cgi_core_type;

    cgi_core_type state_r;
    cgi_core_type state_nxt;
    logic [PINS-1:0] audioSync;
    logic [PINS-1:0] ctrlSync;
    logic apbWr;
    logic apbRd;
    logic busy;

    // ==========================================================
    // pin input synchronisers
    cgi_pin_sync #(.W(PINS)) uAudioSync (
        .clock(clock),
        .nrst(nrst),
        .pinIn(audioPinIn),
        .pinOut(audioSync)
    );

    cgi_pin_sync #(.W(PINS)) uCtrlSync (
        .clock(clock),
        .nrst(nrst),
        .pinIn(ctrlPinIn),
        .pinOut(ctrlSync)
    );

    // ==========================================================
    // helpers
    function automatic logic [31:0] widen(input logic [PORT_W-1:0] v);
        widen = {8'h00, v};
    endfunction

    function automatic cgi_pins_type drivePins(input logic [PORT_W-1:0] fsel,
                                               input logic [PORT_W-1:0] dir,
                                               input logic [PORT_W-1:0] val);
        cgi_pins_type p;
        p.dout = val[PINS-1:0];
        p.oe = ~fsel[PINS-1:0] & dir[PINS-1:0]; // RQ21 RQ4
        drivePins = p;
    endfunction

    assign busy = state_r.fsm != ST_IDLE;
    assign apbWr = apbReq.psel && apbReq.penable && apbReq.pwrite;
    assign apbRd = apbReq.psel && !apbReq.penable && !apbReq.pwrite;

    // ==========================================================
    // next state
    always_comb begin
        state_nxt = state_r;
        // read data captured in setup so it is a register in access phase
        if (apbRd) begin
            case (apbReq.paddr)
                OFF_AUDIO_FSEL: state_nxt.prdata = widen(state_r.audioFsel);
                OFF_CTRL_FSEL: state_nxt.prdata = widen(state_r.ctrlFsel);
                OFF_AUDIO_DIR: state_nxt.prdata = widen(state_r.audioDir);
                OFF_CTRL_DIR: state_nxt.prdata = widen(state_r.ctrlDir);
                OFF_AUDIO_VAL: state_nxt.prdata = widen(state_r.audioVal);
                OFF_CTRL_VAL: state_nxt.prdata = widen(state_r.ctrlVal);
                OFF_WORD_UPPER: state_nxt.prdata = {16'h0000, state_r.wordUpper};
                OFF_WORD_LOWER: state_nxt.prdata = {16'h0000, state_r.wordLower};
                OFF_SEQ_STAT: state_nxt.prdata = {30'h0, state_r.done, busy};
                OFF_AUDIO_PINS: state_nxt.prdata = {26'h0, audioSync};
                OFF_CTRL_PINS: state_nxt.prdata = {26'h0, ctrlSync};
                default: state_nxt.prdata = 32'h00000000;
            endcase
        end
        // software writes; pin values and function selects are locked while busy
        if (apbWr) begin
            case (apbReq.paddr)
                OFF_AUDIO_FSEL: if (!busy) state_nxt.audioFsel = apbReq.pwdata[PORT_W-1:0];
                OFF_CTRL_FSEL: if (!busy) state_nxt.ctrlFsel = apbReq.pwdata[PORT_W-1:0];
                OFF_AUDIO_DIR: state_nxt.audioDir = apbReq.pwdata[PORT_W-1:0];
                OFF_CTRL_DIR: state_nxt.ctrlDir = apbReq.pwdata[PORT_W-1:0];
                OFF_AUDIO_VAL: if (!busy) state_nxt.audioVal = apbReq.pwdata[PORT_W-1:0];
                OFF_CTRL_VAL: if (!busy) state_nxt.ctrlVal = apbReq.pwdata[PORT_W-1:0];
                OFF_WORD_UPPER: state_nxt.wordUpper = apbReq.pwdata[WORD_W-1:0]; // RQ14
                OFF_WORD_LOWER: state_nxt.wordLower = apbReq.pwdata[WORD_W-1:0]; // RQ14
                OFF_SEQ_CTRL: begin
                    if (!busy && apbReq.pwdata[SEQ_INIT]) begin
                        // full init: gpio everywhere, serial unit off
                        state_nxt.audioFsel = FSEL_RST; // RQ3 RQ1
                        state_nxt.ctrlFsel = FSEL_RST; // RQ2
                        state_nxt.audioDir[BIT_RESET] = 1'b1; // RQ5
                        state_nxt.ctrlDir[BIT_SDATA:BIT_SELECT] = 3'b111; // RQ6
                        state_nxt.audioVal[BIT_RESET] = 1'b0; // RQ8
                        state_nxt.ctrlVal[BIT_SELECT] = 1'b0; // RQ9
                        state_nxt.ctrlVal[BIT_SCLK] = 1'b0;
                        state_nxt.cnt = CNT_W'(RESET_WAIT - 1);
                        state_nxt.dummy = 1'b1;
                        state_nxt.done = 1'b0;
                        state_nxt.fsm = ST_RESET; // RQ7
                    end else if (!busy && apbReq.pwdata[SEQ_SEND]) begin
                        // one transfer only on request, no periodic refresh
                        state_nxt.ctrlVal[BIT_SELECT] = 1'b0; // RQ13
                        state_nxt.dummy = 1'b0;
                        state_nxt.done = 1'b0;
                        state_nxt.second = 1'b0;
                        state_nxt.fsm = ST_LOAD;
                    end
                end
                default: ;
            endcase
        end
        // ======================================================
        // sequencer
        case (state_r.fsm)
            ST_IDLE: ;
            ST_RESET: begin
                if (state_r.cnt == '0) begin
                    state_nxt.audioVal[BIT_RESET] = 1'b1; // RQ11 RQ10
                    state_nxt.second = 1'b0;
                    state_nxt.fsm = ST_LOAD;
                end else begin
                    state_nxt.cnt = state_r.cnt - 1'b1; // RQ22
                end
            end
            ST_LOAD: begin
                // dummy set is all zeros; the codec drops it after reset
                state_nxt.shift = state_r.dummy ? '0 :
                    (state_r.second ? state_r.wordLower : state_r.wordUpper); // RQ12 RQ14
                state_nxt.bitCnt = 5'(WORD_W);
                state_nxt.ctrlVal[BIT_SELECT] = 1'b0; // RQ20
                state_nxt.cnt = CNT_W'(HALF_BIT_CYC - 1);
                state_nxt.ctrlVal[BIT_SCLK] = 1'b1;
                state_nxt.ctrlVal[BIT_SDATA] = state_nxt.shift[WORD_W-1]; // RQ19
                state_nxt.fsm = ST_CLKHI;
            end
            ST_CLKHI: begin
                if (state_r.cnt == '0) begin
                    state_nxt.ctrlVal[BIT_SCLK] = 1'b0; // RQ19
                    state_nxt.shift = {state_r.shift[WORD_W-2:0], 1'b0};
                    state_nxt.bitCnt = state_r.bitCnt - 5'd1;
                    state_nxt.cnt = CNT_W'(HALF_BIT_CYC - 1);
                    state_nxt.fsm = ST_CLKLO;
                end else begin
                    state_nxt.cnt = state_r.cnt - 1'b1; // RQ22
                end
            end
            ST_CLKLO: begin
                if (state_r.cnt != '0) begin
                    state_nxt.cnt = state_r.cnt - 1'b1;
                end else if (state_r.bitCnt != 5'd0) begin
                    state_nxt.ctrlVal[BIT_SCLK] = 1'b1;
                    state_nxt.ctrlVal[BIT_SDATA] = state_r.shift[WORD_W-1]; // RQ19
                    state_nxt.cnt = CNT_W'(HALF_BIT_CYC - 1);
                    state_nxt.fsm = ST_CLKHI;
                end else if (!state_r.second) begin
                    state_nxt.second = 1'b1;
                    state_nxt.fsm = ST_LOAD; // RQ14
                end else begin
                    state_nxt.ctrlVal[BIT_SELECT] = 1'b1; // RQ20
                    state_nxt.fsm = ST_END;
                end
            end
            ST_END: begin
                if (state_r.dummy) begin
                    state_nxt.dummy = 1'b0;
                    state_nxt.second = 1'b0;
                    state_nxt.fsm = ST_LOAD; // RQ12
                end else begin
                    // serial unit enabled only now that init is complete
                    state_nxt.audioFsel = AUDIO_FSEL_RUN; // RQ1 RQ3
                    state_nxt.done = 1'b1;
                    state_nxt.fsm = ST_IDLE;
                end
            end
            default: state_nxt.fsm = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_r <= '{audioFsel: FSEL_RST, ctrlFsel: FSEL_RST,
                         audioDir: AUDIO_DIR_RST, ctrlDir: CTRL_DIR_RST,
                         audioVal: AUDIO_VAL_RST, ctrlVal: CTRL_VAL_RST,
                         fsm: ST_IDLE, default: '0};
        end else begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // outputs
    assign audioPins = drivePins(state_r.audioFsel, state_r.audioDir, state_r.audioVal);
    assign ctrlPins = drivePins(state_r.ctrlFsel, state_r.ctrlDir, state_r.ctrlVal);
    assign apbRsp.prdata = state_r.prdata;
    assign apbRsp.pready = 1'b1;
    assign apbRsp.pslverr = 1'b0;

    // ==========================================================
    // assertions
    // trackers for the checks below: init in flight, cycles codec reset held low
    logic initRun;
    logic [CNT_W-1:0] holdCnt;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            initRun <= 1'b0;
            holdCnt <= '0;
        end else begin
            if (state_r.fsm == ST_RESET) initRun <= 1'b1;
            else if (state_r.done) initRun <= 1'b0;
            // saturate so a reset held by software never wraps
            if (state_r.audioVal[BIT_RESET]) holdCnt <= '0;
            else if (holdCnt != '1) holdCnt <= holdCnt + 1'b1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    init_reset_a: assert property (apbWr && apbReq.paddr == OFF_SEQ_CTRL && !busy // RQ8
        && apbReq.pwdata[SEQ_INIT] |=> !state_r.audioVal[BIT_RESET]
        && !state_r.ctrlVal[BIT_SELECT])
        else $error("codec reset or select not asserted at init");
    reset_hold_a: assert property ($rose(state_r.audioVal[BIT_RESET]) && busy |-> // RQ10
        holdCnt >= CNT_W'(RESET_WAIT))
        else $error("codec reset released too early");
    release_first_a: assert property (state_r.fsm == ST_CLKHI |-> // RQ11
        state_r.audioVal[BIT_RESET])
        else $error("control clocked while codec in reset");
    sel_low_a: assert property (state_r.fsm inside {ST_CLKHI, ST_CLKLO} |-> // RQ20
        !state_r.ctrlVal[BIT_SELECT])
        else $error("select high during transfer");
    sel_high_a: assert property (state_r.fsm == ST_END |-> // RQ20
        state_r.ctrlVal[BIT_SELECT])
        else $error("select not returned high after lower word");
    data_stable_a: assert property (!$changed(state_r.ctrlVal[BIT_SCLK]) // RQ19
        && state_r.ctrlVal[BIT_SCLK] |-> $stable(state_r.ctrlVal[BIT_SDATA]))
        else $error("data moved while control clock high");
    serial_off_a: assert property ((state_r.fsm == ST_RESET || initRun) // RQ3
        && !state_r.done |-> state_r.audioFsel == FSEL_RST)
        else $error("serial unit enabled before init done");
    oe_gate_a: assert property (ctrlPins.oe == // RQ21
        (~state_r.ctrlFsel[PINS-1:0] & state_r.ctrlDir[PINS-1:0]))
        else $error("pin driven while not gpio output");
    done_fsel_a: assert property ($rose(state_r.done) |-> // RQ1
        state_r.audioFsel == AUDIO_FSEL_RUN)
        else $error("audio function select wrong after init");

    init_cv: cover property (state_r.fsm == ST_RESET ##1 state_r.fsm == ST_LOAD);
    dummy_cv: cover property (state_r.fsm == ST_END && state_r.dummy);
    done_cv: cover property ($rose(state_r.done));
    send_cv: cover property (apbWr && apbReq.paddr == OFF_SEQ_CTRL
        && apbReq.pwdata[SEQ_SEND]);
endmodule

// file: tb/cgi_codec_model.sv
// behavioural model of the external audio codec on its reset, control and audio link pins
`timescale 1ns/1ps
module cgi_codec_model (
    // reset and control pins
    input wire logic resetN,
    input wire logic selectN,
    input wire logic shiftClk,
    input wire logic serialIn,
    // audio link
    output logic bitClk,
    output logic framePulse,
    // captured control information
    output logic [15:0] wordUpper,
    output logic [15:0] wordLower,
    output int accepted,
    output int seen,
    output int resets,
    output int clkInReset
);
    logic [31:0] shiftReg;
    int nBits;
    int nBclk;
    logic discard;

    initial begin
        {bitClk, framePulse, discard} = 3'b000;
        {wordUpper, wordLower, shiftReg} = '0;
        {accepted, seen, resets, clkInReset, nBits, nBclk} = '0;
    end
    // ==========================================================
    // control interface
    always @(negedge resetN) begin
        resets++;
        discard = 1'b1;
        nBits = 0;
    end
    // data moves in the same step as the clock rise; take it once settled
    always @(posedge shiftClk) begin
        #1;
        if (resetN !== 1'b1) clkInReset++;
        else if (selectN === 1'b0) begin
            shiftReg = {shiftReg[30:0], serialIn};
            nBits++;
        end
    end
    // a set only counts when select closes after exactly two whole words
    always @(posedge selectN) begin
        if (nBits == 32) begin
            seen++;
            if (discard) discard = 1'b0;
            else begin
                wordUpper = shiftReg[31:16];
                wordLower = shiftReg[15:0];
                accepted++;
            end
        end
        nBits = 0;
    end
    // ==========================================================
    // audio link: codec is master, its clock only runs out of reset
    always #400 if (resetN === 1'b1) bitClk = ~bitClk;
    always @(negedge bitClk) begin
        nBclk++;
        framePulse = (nBclk % 32 == 0);
    end
endmodule

// file: tb/cgi_codec_gpio_init_port_tb.sv
// self-checking bench: registers, pin muxing and the codec start-up sequence
`timescale 1ns/1ps
module cgi_codec_gpio_init_port_tb;
    import cgi_pkg::*;
    localparam int RW = 100;
    logic clock;
    logic nrst;
    cgi_apb_req_type apbReq;
    cgi_apb_rsp_type apbRsp;
    cgi_pins_type audioPins;
    cgi_pins_type ctrlPins;
    logic [PINS-1:0] audioWire;
    logic [PINS-1:0] ctrlWire;
    logic bitClk;
    logic framePulse;
    logic [15:0] wordUpper;
    logic [15:0] wordLower;
    int accepted;
    int seen;
    int resets;
    int clkInReset;
    int lowCycles = 0;
    int failures = 0;
    int checks = 0;
    logic [31:0] rd;

    // undriven lines sit at their pull-up, codec drives its bit clock and frame pulse
    assign audioWire = (audioPins.oe & audioPins.dout)
        | (~audioPins.oe & {2'b11, bitClk, framePulse, 2'b11});
    assign ctrlWire = (ctrlPins.oe & ctrlPins.dout) | ~ctrlPins.oe;

    cgi_codec_gpio_init_port #(.RESET_WAIT(RW)) DUT (.clock(clock), .nrst(nrst),
        .apbReq(apbReq), .apbRsp(apbRsp), .audioPinIn(audioWire), .audioPins(audioPins),
        .ctrlPinIn(ctrlWire), .ctrlPins(ctrlPins));
    cgi_codec_model codec (.resetN(audioWire[BIT_RESET]), .selectN(ctrlWire[BIT_SELECT]),
        .shiftClk(ctrlWire[BIT_SCLK]), .serialIn(ctrlWire[BIT_SDATA]), .bitClk(bitClk),
        .framePulse(framePulse), .wordUpper(wordUpper), .wordLower(wordLower),
        .accepted(accepted),
        .seen(seen), .resets(resets), .clkInReset(clkInReset));

    initial clock = 1'b0;
    always #50 clock = ~clock;
    always @(posedge clock) if (audioWire[BIT_RESET] === 1'b0) lowCycles++;
    // ==========================================================
    // helpers
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge clock);
        apbReq.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (apbRsp.pready !== 1'b1 && n < 50);
        rd = apbRsp.prdata;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
        if (apbRsp.pready !== 1'b1) begin
            failures++;
            end_of_test();
        end
    endtask
    task automatic rd_cmp(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        cmp(rd, exp, what);
        cmp({31'h0, apbRsp.pslverr}, 32'h0, "slave error");
    endtask
    task automatic oe_cmp(input logic [5:0] exp);
        @(negedge clock);
        cmp({26'h0, ctrlPins.oe}, {26'h0, exp}, "ctrl oe");
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        do begin
            apb(1'b0, OFF_SEQ_STAT, 32'h0);
            n++;
        end while (rd[STAT_DONE] !== 1'b1 && n < 2000);
        if (n >= 2000) begin
            failures++;
            end_of_test();
        end
    endtask
    // ==========================================================
    // scenarios
    task automatic test_reset_values();
        rd_cmp(OFF_AUDIO_FSEL, 32'h0, "audio fsel");
        rd_cmp(OFF_CTRL_FSEL, 32'h0, "ctrl fsel");
        rd_cmp(OFF_AUDIO_DIR, 32'h1, "audio dir");
        rd_cmp(OFF_CTRL_DIR, 32'h7, "ctrl dir");
        rd_cmp(OFF_SEQ_STAT, 32'h0, "status");
        apb(1'b1, 8'h3c, 32'hffff);
        rd_cmp(8'h3c, 32'h0, "unmapped");
        rd_cmp(OFF_CTRL_PINS, 32'h39, "ctrl wires");
        apb(1'b0, OFF_AUDIO_PINS, 32'h0);
        cmp(rd & 32'h33, 32'h33, "audio wires");
    endtask
    task automatic test_pin_mux();
        apb(1'b1, OFF_CTRL_VAL, 32'h5);
        // pin reads lag the pins by the input synchroniser
        repeat (4) @(posedge clock);
        rd_cmp(OFF_CTRL_PINS, 32'h3d, "ctrl wires");
        apb(1'b1, OFF_CTRL_FSEL, 32'h4);
        oe_cmp(6'h03);
        apb(1'b1, OFF_CTRL_FSEL, 32'h0);
        apb(1'b1, OFF_CTRL_DIR, 32'h2);
        oe_cmp(6'h02);
        apb(1'b1, OFF_CTRL_DIR, 32'h7);
        apb(1'b1, OFF_CTRL_VAL, 32'h1);
        oe_cmp(6'h07);
    endtask
    task automatic test_init();
        int n;
        apb(1'b1, OFF_WORD_UPPER, 32'ha5c3);
        apb(1'b1, OFF_WORD_LOWER, 32'h1234);
        apb(1'b1, OFF_SEQ_CTRL, 32'h1);
        n = 0;
        while (audioWire[BIT_RESET] !== 1'b0 && n < 4) begin
            @(negedge clock);
            n++;
        end
        cmp({31'h0, audioWire[BIT_RESET]}, 32'h0, "codec reset");
        cmp({31'h0, ctrlWire[BIT_SELECT]}, 32'h0, "select");
        apb(1'b1, OFF_AUDIO_FSEL, 32'h3f);
        rd_cmp(OFF_AUDIO_FSEL, 32'h0, "fsel locked");
        rd_cmp(OFF_SEQ_STAT, 32'h1, "busy");
        wait_done();
        cmp({31'h0, lowCycles >= RW}, 32'h1, "reset hold");
        rd_cmp(OFF_AUDIO_FSEL, 32'h3e, "fsel after init");
        cmp(32'(resets), 32'h1, "resets");
        cmp(32'(clkInReset), 32'h0, "clock in reset");
        cmp(32'(seen), 32'h2, "sets seen");
        cmp(32'(accepted), 32'h1, "sets accepted");
        cmp({16'h0, wordUpper}, 32'ha5c3, "upper");
        cmp({16'h0, wordLower}, 32'h1234, "lower");
        cmp({31'h0, ctrlWire[BIT_SELECT]}, 32'h1, "select high");
    endtask
    task automatic test_send();
        apb(1'b1, OFF_WORD_UPPER, 32'h8001);
        apb(1'b1, OFF_WORD_LOWER, 32'h7ffe);
        apb(1'b1, OFF_SEQ_CTRL, 32'h2);
        apb(1'b1, OFF_SEQ_CTRL, 32'h1);
        wait_done();
        cmp(32'(resets), 32'h1, "no new reset");
        cmp(32'(accepted), 32'h2, "sets accepted");
        cmp({16'h0, wordUpper}, 32'h8001, "upper");
        cmp({16'h0, wordLower}, 32'h7ffe, "lower");
        rd_cmp(OFF_AUDIO_FSEL, 32'h3e, "fsel after send");
    endtask
    // ==========================================================
    // main sequence
    initial begin
        nrst = 1'b0;
        apbReq = '0;
        repeat (10) @(posedge clock);
        nrst <= 1'b1;
        test_reset_values();
        test_pin_mux();
        test_init();
        test_send();
        end_of_test();
    end
    initial begin
        #10_000_000;
        failures++;
        end_of_test();
    end
endmodule
